// >>> design/vat_pkg.sv
package vat_pkg;

  // widths
  localparam int VA_W      = 64;
  localparam int PA_W      = 32;
  localparam int TAG_W     = 8;
  localparam int VPN_W     = 30;
  localparam int PFN_W     = 22;
  localparam int MIN_OFS_W = 10;
  localparam int SIZE_W    = 3;
  localparam int CATTR_W   = 3;
  localparam int REG_AW    = 8;
  localparam int REG_DW    = 32;

  // register offsets
  localparam logic [REG_AW-1:0] REG_STATUS     = 8'h00;
  localparam logic [REG_AW-1:0] REG_ENTRY_HIGH = 8'h04;
  localparam logic [REG_AW-1:0] REG_ENTRY_VPN  = 8'h08;
  localparam logic [REG_AW-1:0] REG_ENTRY_LOW  = 8'h0C;
  localparam logic [REG_AW-1:0] REG_PAGE_SIZE  = 8'h10;
  localparam logic [REG_AW-1:0] REG_INDEX      = 8'h14;
  localparam logic [REG_AW-1:0] REG_RESULT     = 8'h18;

  // status register fields
  localparam int ST_PRIV_LSB = 0;
  localparam int ST_EXL      = 2;
  localparam int ST_ERL      = 3;
  localparam int ST_UX       = 4;
  localparam int ST_SX       = 5;
  localparam logic [5:0] STATUS_RST = 6'h00;

  // entry staging fields
  localparam int EH_REGION_LSB = 30;
  localparam int EL_CATTR_LSB  = 22;
  localparam int EL_GLOBAL     = 25;

  // result register fields
  localparam int RS_IDX_LSB = 8;

  // encodings
  localparam logic [1:0]         PRIV_KERNEL    = 2'h0;
  localparam logic [1:0]         PRIV_SUPER     = 2'h1;
  localparam logic [1:0]         PRIV_USER      = 2'h2;
  localparam logic [SIZE_W-1:0]  SIZE_MAX       = 3'h4;
  localparam logic [CATTR_W-1:0] CATTR_UNCACHED = 3'h2;
  localparam logic [2:0]         SUPER32_TOP    = 3'h6;
  localparam logic [1:0]         REGION_USER    = 2'h0;
  localparam logic [1:0]         REGION_SUPER   = 2'h1;
  localparam logic [1:0]         REGION_COMPAT  = 2'h3;

  typedef enum logic [2:0] {
    MODE_KERNEL,
    MODE_USER32,
    MODE_USER64,
    MODE_SUPER32,
    MODE_SUPER64
  } vat_mode_t;

endpackage : vat_pkg

// >>> design/vat_translate.sv
// Our own choices: the strobed register port and the placing of the registers.
module vat_translate #(
  parameter int NUM_ENTRIES = 32
) (
  input  wire logic                          clock,                  // core clock
  input  wire logic                          reset,                  // sync, active high
  input  wire logic [vat_pkg::REG_AW-1:0]    reg_addr,               // register offset
  input  wire logic [vat_pkg::REG_DW-1:0]    reg_wdata,              // write data
  input  wire logic                          reg_wr,                 // write strobe
  input  wire logic                          reg_rd,                 // read strobe
  output logic      [vat_pkg::REG_DW-1:0]    reg_rdata,              // read data, next cycle
  input  wire logic                          req_valid,              // address presented
  input  wire logic [vat_pkg::VA_W-1:0]      req_vaddr,              // virtual address
  input  wire logic                          exception_return_instr, // return from exception
  output logic                               rsp_valid,              // result strobe
  output logic      [vat_pkg::PA_W-1:0]      rsp_paddr,              // physical address
  output logic                               rsp_hit,                // translated
  output logic                               rsp_miss,               // mismatch exception
  output logic                               rsp_miss_extended,      // use extended vector
  output logic                               rsp_addr_error,         // address error exception
  output logic                               rsp_cached,             // access is cached
  output logic      [vat_pkg::CATTR_W-1:0]   rsp_cache_attr,         // entry cache field
  output logic                               rsp_kernel              // kernel, not checked here
);

  localparam int IDX_W = (NUM_ENTRIES > 1) ? $clog2(NUM_ENTRIES) : 1;

  // software-visible control
  logic [1:0]                  privilege_field_ff;
  logic                        exception_level_bit_ff;
  logic                        error_level_bit_ff;
  logic                        user_wide_addr_bit_ff;
  logic                        supervisor_wide_addr_bit_ff;
  logic [vat_pkg::TAG_W-1:0]   address_space_tag_ff;
  logic [vat_pkg::VPN_W-1:0]   stage_vpn_ff;
  logic [1:0]                  stage_region_ff;
  logic [vat_pkg::PFN_W-1:0]   stage_pfn_ff;
  logic [vat_pkg::CATTR_W-1:0] stage_cattr_ff;
  logic                        stage_global_ff;
  logic [vat_pkg::SIZE_W-1:0]  stage_size_ff;
  logic [IDX_W-1:0]            index_ff;
  // translation entries
  logic                        ent_valid_ff  [NUM_ENTRIES];
  logic [vat_pkg::VPN_W-1:0]   ent_vpn_ff    [NUM_ENTRIES];
  logic [1:0]                  ent_region_ff [NUM_ENTRIES];
  logic [vat_pkg::TAG_W-1:0]   ent_tag_ff    [NUM_ENTRIES];
  logic                        ent_global_ff [NUM_ENTRIES];
  logic [vat_pkg::SIZE_W-1:0]  ent_size_ff   [NUM_ENTRIES];
  logic [vat_pkg::PFN_W-1:0]   ent_pfn_ff    [NUM_ENTRIES];
  logic [vat_pkg::CATTR_W-1:0] ent_cattr_ff  [NUM_ENTRIES];
  // last result, readable
  logic                        last_err_ff;
  logic                        last_miss_ff;
  logic                        last_ext_ff;
  logic                        last_hit_ff;
  logic [IDX_W-1:0]            last_idx_ff;
  vat_pkg::vat_mode_t          mode;
  logic                        wide;
  logic [vat_pkg::VA_W-1:0]    va;
  logic                        seg_ok;
  logic [NUM_ENTRIES-1:0]      hit_vec;
  logic                        hit_any;
  logic [IDX_W-1:0]            hit_idx;
  logic [vat_pkg::PA_W-1:0]    pa;
  logic                        exc_event;
  logic                        mapped_req;
  logic                        status_wr;
  logic [vat_pkg::REG_DW-1:0]  nxt_rdata;

  function automatic vat_pkg::vat_mode_t decode_mode(
    input logic [1:0] priv,
    input logic       exception_level_bit,
    input logic       error_level_bit,
    input logic       ux,
    input logic       sx
  );
    vat_pkg::vat_mode_t m;
    m = vat_pkg::MODE_KERNEL;                 // field 11 also lands here, the safe side
    if (!exception_level_bit && !error_level_bit && priv == vat_pkg::PRIV_USER) begin
      m = ux ? vat_pkg::MODE_USER64 : vat_pkg::MODE_USER32;
    end else if (!exception_level_bit && !error_level_bit && priv == vat_pkg::PRIV_SUPER) begin
      m = sx ? vat_pkg::MODE_SUPER64 : vat_pkg::MODE_SUPER32;
    end
    return m;
  endfunction : decode_mode
  // clip sizes above 256K so an illegal code cannot open a larger page
  function automatic logic [vat_pkg::SIZE_W-1:0] clip_size(
    input logic [vat_pkg::SIZE_W-1:0] size
  );
    return (size > vat_pkg::SIZE_MAX) ? vat_pkg::SIZE_MAX : size;
  endfunction : clip_size
  // page number bits that take part in the compare
  function automatic logic [vat_pkg::VPN_W-1:0] vpn_mask(
    input logic [vat_pkg::SIZE_W-1:0] size
  );
    logic [vat_pkg::VPN_W-1:0] low;
    low = (vat_pkg::VPN_W'(1) << (2 * clip_size(size))) - vat_pkg::VPN_W'(1);
    return ~low;
  endfunction : vpn_mask
  // offset bits passed through untranslated
  function automatic logic [vat_pkg::PA_W-1:0] ofs_mask(
    input logic [vat_pkg::SIZE_W-1:0] size
  );
    return (vat_pkg::PA_W'(1) << (vat_pkg::MIN_OFS_W + 2 * clip_size(size)))
           - vat_pkg::PA_W'(1);
  endfunction : ofs_mask

  assign mode      = decode_mode(privilege_field_ff, exception_level_bit_ff,
                                 error_level_bit_ff, user_wide_addr_bit_ff,
                                 supervisor_wide_addr_bit_ff);
  assign wide      = (mode == vat_pkg::MODE_USER64) || (mode == vat_pkg::MODE_SUPER64);
  assign va        = wide ? req_vaddr
                          : {{32{req_vaddr[31]}}, req_vaddr[31:0]};
  assign status_wr = reg_wr && (reg_addr == vat_pkg::REG_STATUS);

  // segment legality for the current privilege and width
  always_comb begin
    seg_ok = 1'b0;
    unique case (mode)
      vat_pkg::MODE_KERNEL:  seg_ok = 1'b1;
      vat_pkg::MODE_USER32:  seg_ok = !va[31];
      vat_pkg::MODE_USER64:  seg_ok = (va[63:40] == 24'h000000);
      vat_pkg::MODE_SUPER32: seg_ok = !va[31] ||
                                      (va[31:29] == vat_pkg::SUPER32_TOP);
      vat_pkg::MODE_SUPER64: begin
        unique case (va[63:62])
          vat_pkg::REGION_USER:   seg_ok = (va[61:40] == 22'h000000);
          vat_pkg::REGION_SUPER:  seg_ok = (va[61:40] == 22'h000000);
          vat_pkg::REGION_COMPAT: seg_ok = (va[61:32] == 30'h3FFFFFFF) &&
                                           (va[31:29] == vat_pkg::SUPER32_TOP);
          default:                seg_ok = 1'b0;
        endcase
      end
      default: seg_ok = 1'b0;
    endcase
  end
  // parallel compare; 32-bit addresses land on the same entries because
  // bits 39..32 of a sign-extended address simply repeat bit 31
  for (genvar g = 0; g < NUM_ENTRIES; g++) begin : g_match
    assign hit_vec[g] = ent_valid_ff[g] &&
                        (ent_region_ff[g] == va[63:62]) &&
                        (((ent_vpn_ff[g] ^ va[39:10]) & vpn_mask(ent_size_ff[g]))
                         == '0) &&
                        (ent_global_ff[g] ||
                         (ent_tag_ff[g] == address_space_tag_ff));
  end

  // lowest index wins if software loaded overlapping entries
  always_comb begin
    hit_any = 1'b0;
    hit_idx = '0;
    for (int i = NUM_ENTRIES - 1; i >= 0; i--) begin
      if (hit_vec[i]) begin
        hit_any = 1'b1;
        hit_idx = IDX_W'(i);
      end
    end
  end
  assign pa = ({ent_pfn_ff[hit_idx], 10'h000} & ~ofs_mask(ent_size_ff[hit_idx])) |
              (va[31:0] & ofs_mask(ent_size_ff[hit_idx]));
  assign mapped_req = req_valid && (mode != vat_pkg::MODE_KERNEL);
  assign exc_event  = mapped_req && (!seg_ok || !hit_any);

  // response, one cycle after the request
  always_ff @(posedge clock) begin
    if (reset) begin
      rsp_valid         <= 1'b0;
      rsp_paddr         <= '0;
      rsp_hit           <= 1'b0;
      rsp_miss          <= 1'b0;
      rsp_miss_extended <= 1'b0;
      rsp_addr_error    <= 1'b0;
      rsp_cached        <= 1'b0;
      rsp_cache_attr    <= '0;
      rsp_kernel        <= 1'b0;
    end else begin
      rsp_valid         <= req_valid;
      rsp_kernel        <= req_valid && (mode == vat_pkg::MODE_KERNEL);
      rsp_addr_error    <= mapped_req && !seg_ok;
      rsp_hit           <= mapped_req && seg_ok && hit_any;
      rsp_miss          <= mapped_req && seg_ok && !hit_any;
      rsp_miss_extended <= mapped_req && seg_ok && !hit_any && wide;
      rsp_paddr         <= (mapped_req && seg_ok && hit_any) ? pa : '0;
      rsp_cache_attr    <= (mapped_req && seg_ok && hit_any) ? ent_cattr_ff[hit_idx] : '0;
      rsp_cached        <= mapped_req && seg_ok && hit_any &&
                           (ent_cattr_ff[hit_idx] != vat_pkg::CATTR_UNCACHED);
    end
  end

  // privilege state; hardware exception entry beats a same-cycle clear
  always_ff @(posedge clock) begin
    if (reset) begin
      privilege_field_ff          <= vat_pkg::STATUS_RST[vat_pkg::ST_PRIV_LSB +: 2];
      exception_level_bit_ff      <= vat_pkg::STATUS_RST[vat_pkg::ST_EXL];
      error_level_bit_ff          <= vat_pkg::STATUS_RST[vat_pkg::ST_ERL];
      user_wide_addr_bit_ff       <= vat_pkg::STATUS_RST[vat_pkg::ST_UX];
      supervisor_wide_addr_bit_ff <= vat_pkg::STATUS_RST[vat_pkg::ST_SX];
    end else begin
      if (status_wr) begin
        privilege_field_ff          <= reg_wdata[vat_pkg::ST_PRIV_LSB +: 2];
        exception_level_bit_ff      <= reg_wdata[vat_pkg::ST_EXL];
        error_level_bit_ff          <= reg_wdata[vat_pkg::ST_ERL];
        user_wide_addr_bit_ff       <= reg_wdata[vat_pkg::ST_UX];
        supervisor_wide_addr_bit_ff <= reg_wdata[vat_pkg::ST_SX];
      end
      if (exception_return_instr) begin
        if (error_level_bit_ff) begin
          error_level_bit_ff <= 1'b0;
        end else begin
          exception_level_bit_ff <= 1'b0;
        end
      end
      if (exc_event) begin
        exception_level_bit_ff <= 1'b1;
      end
    end
  end

  // tag and entry staging registers
  always_ff @(posedge clock) begin
    if (reset) begin
      address_space_tag_ff <= '0;
      stage_vpn_ff         <= '0;
      stage_region_ff      <= '0;
      stage_pfn_ff         <= '0;
      stage_cattr_ff       <= '0;
      stage_global_ff      <= 1'b0;
      stage_size_ff        <= '0;
    end else if (reg_wr) begin
      unique case (reg_addr)
        vat_pkg::REG_ENTRY_HIGH: address_space_tag_ff <= reg_wdata[vat_pkg::TAG_W-1:0];
        vat_pkg::REG_ENTRY_VPN: begin
          stage_vpn_ff    <= reg_wdata[vat_pkg::VPN_W-1:0];
          stage_region_ff <= reg_wdata[vat_pkg::EH_REGION_LSB +: 2];
        end
        vat_pkg::REG_ENTRY_LOW: begin
          stage_pfn_ff    <= reg_wdata[vat_pkg::PFN_W-1:0];
          stage_cattr_ff  <= reg_wdata[vat_pkg::EL_CATTR_LSB +: vat_pkg::CATTR_W];
          stage_global_ff <= reg_wdata[vat_pkg::EL_GLOBAL];
        end
        vat_pkg::REG_PAGE_SIZE: stage_size_ff <= reg_wdata[vat_pkg::SIZE_W-1:0];
        default: ;
      endcase
    end
  end

  // writing the index commits the staged entry; the tag is captured too
  always_ff @(posedge clock) begin
    if (reset) begin
      index_ff <= '0;
      for (int i = 0; i < NUM_ENTRIES; i++) begin
        ent_valid_ff[i] <= 1'b0; // data fields left unreset; valid gates every use
      end
    end else if (reg_wr && reg_addr == vat_pkg::REG_INDEX) begin
      index_ff                 <= reg_wdata[IDX_W-1:0];
      ent_valid_ff[reg_wdata[IDX_W-1:0]]  <= 1'b1;
      ent_vpn_ff[reg_wdata[IDX_W-1:0]]    <= stage_vpn_ff;
      ent_region_ff[reg_wdata[IDX_W-1:0]] <= stage_region_ff;
      ent_tag_ff[reg_wdata[IDX_W-1:0]]    <= address_space_tag_ff;
      ent_global_ff[reg_wdata[IDX_W-1:0]] <= stage_global_ff;
      ent_size_ff[reg_wdata[IDX_W-1:0]]   <= stage_size_ff;
      ent_pfn_ff[reg_wdata[IDX_W-1:0]]    <= stage_pfn_ff;
      ent_cattr_ff[reg_wdata[IDX_W-1:0]]  <= stage_cattr_ff;
    end
  end

  // last translation outcome for software
  always_ff @(posedge clock) begin
    if (reset) begin
      last_err_ff  <= 1'b0;
      last_miss_ff <= 1'b0;
      last_ext_ff  <= 1'b0;
      last_hit_ff  <= 1'b0;
      last_idx_ff  <= '0;
    end else if (req_valid && mode != vat_pkg::MODE_KERNEL) begin
      last_err_ff  <= !seg_ok;
      last_miss_ff <= seg_ok && !hit_any;
      last_ext_ff  <= seg_ok && !hit_any && wide;
      last_hit_ff  <= seg_ok && hit_any;
      last_idx_ff  <= hit_idx;
    end
  end

  always_comb begin
    nxt_rdata = '0;
    unique case (reg_addr)
      vat_pkg::REG_STATUS: begin
        nxt_rdata[vat_pkg::ST_PRIV_LSB +: 2] = privilege_field_ff;
        nxt_rdata[vat_pkg::ST_EXL]           = exception_level_bit_ff;
        nxt_rdata[vat_pkg::ST_ERL]           = error_level_bit_ff;
        nxt_rdata[vat_pkg::ST_UX]            = user_wide_addr_bit_ff;
        nxt_rdata[vat_pkg::ST_SX]            = supervisor_wide_addr_bit_ff;
      end
      vat_pkg::REG_ENTRY_HIGH: nxt_rdata[vat_pkg::TAG_W-1:0] = address_space_tag_ff;
      vat_pkg::REG_ENTRY_VPN: begin
        nxt_rdata[vat_pkg::VPN_W-1:0]          = stage_vpn_ff;
        nxt_rdata[vat_pkg::EH_REGION_LSB +: 2] = stage_region_ff;
      end
      vat_pkg::REG_ENTRY_LOW: begin
        nxt_rdata[vat_pkg::PFN_W-1:0]                         = stage_pfn_ff;
        nxt_rdata[vat_pkg::EL_CATTR_LSB +: vat_pkg::CATTR_W] = stage_cattr_ff;
        nxt_rdata[vat_pkg::EL_GLOBAL]                         = stage_global_ff;
      end
      vat_pkg::REG_PAGE_SIZE: nxt_rdata[vat_pkg::SIZE_W-1:0] = stage_size_ff;
      vat_pkg::REG_INDEX:     nxt_rdata[IDX_W-1:0]           = index_ff;
      vat_pkg::REG_RESULT: begin
        nxt_rdata[0]                          = last_err_ff;
        nxt_rdata[1]                          = last_miss_ff;
        nxt_rdata[2]                          = last_ext_ff;
        nxt_rdata[3]                          = last_hit_ff;
        nxt_rdata[vat_pkg::RS_IDX_LSB +: IDX_W] = last_idx_ff;
      end
      default: nxt_rdata = '0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? nxt_rdata : '0;
    end
  end

  // checks
  sequence seq_user32_high;
    req_valid && mode == vat_pkg::MODE_USER32 && req_vaddr[31];
  endsequence
  sequence seq_exc_then_req;
    exc_event ##1 (req_valid && !status_wr);
  endsequence

  user32_high_err_a: assert property (@(posedge clock) disable iff (reset)
    seq_user32_high |=> rsp_addr_error && !rsp_hit && !rsp_miss)
    else $error("user 32-bit high address not rejected");
  user64_range_err_a: assert property (@(posedge clock) disable iff (reset)
    req_valid && mode == vat_pkg::MODE_USER64 && req_vaddr[63:40] != 24'h000000
    |=> rsp_addr_error)
    else $error("user 64-bit address above 1 TB not rejected");
  user32_low_ok_a: assert property (@(posedge clock) disable iff (reset)
    req_valid && mode == vat_pkg::MODE_USER32 && !req_vaddr[31]
    |=> !rsp_addr_error && (rsp_hit || rsp_miss))
    else $error("user 32-bit low address wrongly rejected");
  sup32_seg_ok_a: assert property (@(posedge clock) disable iff (reset)
    req_valid && mode == vat_pkg::MODE_SUPER32 && req_vaddr[31:29] == 3'h6
    |=> !rsp_addr_error)
    else $error("supervisor segment wrongly rejected");
  sup64_hole_err_a: assert property (@(posedge clock) disable iff (reset)
    req_valid && mode == vat_pkg::MODE_SUPER64 && req_vaddr[63:62] == 2'h2
    |=> rsp_addr_error)
    else $error("supervisor 64-bit hole not rejected");
  exc_kernel_a: assert property (@(posedge clock) disable iff (reset)
    seq_exc_then_req |=> rsp_kernel && !rsp_addr_error)
    else $error("exception did not force kernel");
  exception_return_instr_restore_a: assert property (@(posedge clock) disable iff (reset)
    exception_return_instr && exception_level_bit_ff && !error_level_bit_ff &&
    !exc_event && !status_wr |=> !exception_level_bit_ff)
    else $error("exception return did not clear level");
  miss_vector_a: assert property (@(posedge clock) disable iff (reset)
    rsp_miss |-> rsp_miss_extended == $past(wide))
    else $error("wrong mismatch vector");
  hit_offset_a: assert property (@(posedge clock) disable iff (reset)
    rsp_hit |-> rsp_paddr[9:0] == $past(req_vaddr[9:0]))
    else $error("offset bits altered");
  kernel_override_a: assert property (@(posedge clock) disable iff (reset)
    req_valid && (exception_level_bit_ff || error_level_bit_ff ||
                  privilege_field_ff == 2'h0)
    |=> rsp_kernel && !rsp_hit && !rsp_miss)
    else $error("kernel override missed");
  cache_attr_a: assert property (@(posedge clock) disable iff (reset)
    rsp_hit |-> rsp_cached == (rsp_cache_attr != 3'h2))
    else $error("cacheability not from entry");

endmodule : vat_translate

// >>> sim/vat_pipe_model.sv
module vat_pipe_model (
  input  wire logic        clock,      // core clock
  input  wire logic        issue,      // stage holds an access
  input  wire logic [63:0] issue_addr, // address of that access
  output logic             req_valid,  // request to translator
  output logic      [63:0] req_vaddr   // virtual address
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    req_valid = 1'b0;
    req_vaddr = 64'h0;
  end
  // idle address toggles so nothing leans on a stale value
  always @(posedge clock) begin
    req_valid <= issue;
    req_vaddr <= issue ? issue_addr : ~req_vaddr;
  end
endmodule : vat_pipe_model

// >>> sim/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [5:0]  st;
    logic [63:0] va;
    logic [4:0]  fl;
    logic [31:0] pa;
  } vat_row_t;
  // fl is kernel, address error, miss, extended, hit
  localparam vat_row_t ROWS [13] = '{
    '{6'h02, 64'h0000_0000_0000_1234, 5'h01, 32'h0001_5634},
    '{6'h02, 64'h0000_0000_8000_0000, 5'h08, 32'h0},
    '{6'h02, 64'h0000_0000_0000_5000, 5'h04, 32'h0},
    '{6'h02, 64'hFFFF_FFFF_0000_1234, 5'h01, 32'h0001_5634},
    '{6'h12, 64'h0000_0000_0000_1234, 5'h01, 32'h0001_5634},
    '{6'h12, 64'h0000_0100_0000_0000, 5'h08, 32'h0},
    '{6'h12, 64'h0000_00FF_0000_0000, 5'h06, 32'h0},
    '{6'h01, 64'h0000_0000_C000_0000, 5'h04, 32'h0},
    '{6'h01, 64'h0000_0000_E000_0000, 5'h08, 32'h0},
    '{6'h21, 64'h4000_0000_0000_1234, 5'h06, 32'h0},
    '{6'h21, 64'h8000_0000_0000_0000, 5'h08, 32'h0},
    '{6'h06, 64'h0000_0000_0000_1234, 5'h10, 32'h0},
    '{6'h00, 64'h0000_0000_0000_1234, 5'h10, 32'h0}
  };
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        xret = 1'b0;
  logic [2:0]  exp_attr = 3'h3;
  logic [2:0]  rsp_attr;
  logic        issue = 1'b0;
  logic [63:0] issue_addr = 64'h0;
  logic [63:0] req_vaddr;
  logic [31:0] reg_rdata, rsp_paddr;
  logic        req_valid, rsp_valid, rsp_hit, rsp_miss, rsp_ext, rsp_err, rsp_cached, rsp_kernel;
  int          n_fail = 0;
  int          checks = 0;
  always #10 clock = ~clock;
  vat_pipe_model i_pipe (.clock(clock), .issue(issue), .issue_addr(issue_addr),
    .req_valid(req_valid), .req_vaddr(req_vaddr));
  vat_translate #(.NUM_ENTRIES(4)) i_dut (.clock(clock), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .req_valid(req_valid), .req_vaddr(req_vaddr), .exception_return_instr(xret),
    .rsp_valid(rsp_valid), .rsp_paddr(rsp_paddr), .rsp_hit(rsp_hit), .rsp_miss(rsp_miss),
    .rsp_miss_extended(rsp_ext), .rsp_addr_error(rsp_err), .rsp_cached(rsp_cached),
    .rsp_cache_attr(rsp_attr), .rsp_kernel(rsp_kernel));
  task automatic tally_and_finish();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    chk("reg_rdata", {32'h0, exp}, {32'h0, reg_rdata});
  endtask : rd
  task automatic look(input logic [4:0] fl, input logic [31:0] pa);
    @(negedge clock);
    chk("response", {22'h0, (fl[0] ? exp_attr : 3'h0), 1'b1, fl, pa,
      (fl[0] && exp_attr != 3'h2)}, {22'h0, rsp_attr, rsp_valid, rsp_kernel, rsp_err, rsp_miss,
      rsp_ext, rsp_hit, rsp_paddr, rsp_cached});
  endtask : look
  task automatic go(input vat_row_t r);
    wr(8'h00, {26'h0, r.st});
    @(posedge clock);
    issue      <= 1'b1;
    issue_addr <= r.va;
    @(posedge clock);
    issue <= 1'b0;
    @(posedge clock);
    look(r.fl, r.pa);
  endtask : go
  initial begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    rd(8'h00, 32'h0);
    rd(8'h40, 32'h0);
    wr(8'h04, 32'h5);
    wr(8'h08, 32'h4);
    wr(8'h0C, 32'h00C0_0055);
    wr(8'h10, 32'h0);
    wr(8'h14, 32'h0);
    foreach (ROWS[i]) go(ROWS[i]);
    // back to back: the miss drops the following access into kernel
    wr(8'h00, 32'h02);
    @(posedge clock);
    issue      <= 1'b1;
    issue_addr <= 64'h5000;
    @(posedge clock);
    issue_addr <= 64'h1234;
    @(posedge clock);
    issue <= 1'b0;
    look(5'h04, 32'h0);
    look(5'h10, 32'h0);
    rd(8'h00, 32'h06);
    @(posedge clock);
    xret <= 1'b1;
    @(posedge clock);
    xret <= 1'b0;
    rd(8'h00, 32'h02);
    wr(8'h04, 32'h6);
    go('{6'h02, 64'h1234, 5'h04, 32'h0});
    wr(8'h0C, 32'h02C0_0055);
    wr(8'h14, 32'h0);
    wr(8'h04, 32'h5);
    go('{6'h02, 64'h1234, 5'h01, 32'h0001_5634});
    // same page, now marked uncached
    exp_attr = 3'h2;
    wr(8'h0C, 32'h0280_0055);
    wr(8'h14, 32'h0);
    go('{6'h02, 64'h1234, 5'h01, 32'h0001_5634});
    // 256K page in a second entry: all 18 offset bits pass through
    wr(8'h10, 32'h4);
    wr(8'h14, 32'h1);
    go('{6'h02, 64'h2_ABCD, 5'h01, 32'h0002_ABCD});
    rd(8'h18, 32'h0000_0108);
    // mid-run reset drops every entry and returns to kernel
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    rd(8'h18, 32'h0);
    rd(8'h00, 32'h0);
    go('{6'h02, 64'h1234, 5'h04, 32'h0});
    tally_and_finish();
  end
  initial begin
    #20000;
    n_fail++;
    tally_and_finish();
  end
endmodule : testbench
